// ### lssr_consts.vh
// constants for the link and sensor status register bank
`ifndef LSSR_CONSTS_VH
`define LSSR_CONSTS_VH

// ==========================================
// register indices (byte address = 4 * index)
`define LSSR_IDX_GEN_STATUS 8'h52
`define LSSR_IDX_GPIO_LEVELS 8'h53
`define LSSR_IDX_SELFTEST_CNT 8'h54
`define LSSR_IDX_CHECK_CNT_LO 8'h55
`define LSSR_IDX_CHECK_CNT_HI 8'h56
`define LSSR_IDX_ALARM_FLAGS 8'h57
`define LSSR_IDX_PIN0_EXTREMES 8'h58
`define LSSR_IDX_PIN1_EXTREMES 8'h59
`define LSSR_IDX_BACKLINK_CTRL 8'h49

// ==========================================
// general status fields
`define LSSR_GS_PRESENT 0
`define LSSR_GS_CHECK_FAIL 1
`define LSSR_GS_SYNTH_LOCK 2
`define LSSR_GS_SELFTEST_FAIL 3
`define LSSR_GS_LOSS_CHANGE 4
`define LSSR_GS_REMOTE_LOCK 6

// ==========================================
// control register fields
`define LSSR_CTRL_CHECK_CLR 3
`define LSSR_CTRL_SELFTEST_CLR 5

// ==========================================
// alarm flag fields
`define LSSR_AL_TEMP_OVER 5
`define LSSR_AL_TEMP_UNDER 4
`define LSSR_AL_PIN1_OVER 3
`define LSSR_AL_PIN1_UNDER 2
`define LSSR_AL_PIN0_OVER 1
`define LSSR_AL_PIN0_UNDER 0

// ==========================================
// reset values
`define LSSR_RST_PRESENT 1'h1
`define LSSR_RST_SYNTH_LOCK 1'h1
`define LSSR_RST_PEAK 3'h0
`define LSSR_RST_TROUGH 3'h7

`endif

// ### lssr_sat_counter.v
// saturating event counter with synchronous clear
`timescale 1ns/10ps
module lssr_sat_counter #(
   parameter WIDTH = 8
) (
   input wire sys_clk_i, // system clock
   input wire reset_i, // synchronous reset
   input wire clear_i, // clear to zero
   input wire event_i, // one count
   output reg [WIDTH-1:0] count_o // count value
);
   // ==========================================
   // counting
   always @(posedge sys_clk_i) begin
      if (reset_i || clear_i) begin
         count_o <= {WIDTH{1'b0}};
      end else if (event_i && !(&count_o)) begin
         count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule

// ### lssr_extreme_catch.v
// peak and trough catcher for one 3-bit sensor reading
`timescale 1ns/10ps
`include "lssr_consts.vh"
module lssr_extreme_catch (
   input wire sys_clk_i, // system clock
   input wire reset_i, // synchronous reset
   input wire [2:0] reading_i, // current sensor reading
   input wire over_i, // reading above upper limit
   input wire under_i, // reading below lower limit
   input wire read_clear_i, // register read, clear fields
   output reg [2:0] peak_o, // highest reading while over
   output reg [2:0] trough_o // lowest reading while under
);
   // ==========================================
   // capture; a new extreme in the clearing cycle is kept
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         peak_o <= `LSSR_RST_PEAK;
         trough_o <= `LSSR_RST_TROUGH;
      end else begin
         if (over_i && (read_clear_i || reading_i > peak_o)) begin
            peak_o <= reading_i;
         end else if (read_clear_i) begin
            peak_o <= `LSSR_RST_PEAK;
         end
         if (under_i && (read_clear_i || reading_i < trough_o)) begin
            trough_o <= reading_i;
         end else if (read_clear_i) begin
            trough_o <= `LSSR_RST_TROUGH;
         end
      end
   end
endmodule

// ### lssr_status_regs.v
// link and sensor status register bank with apb slave
//
// Operation
// - loss-change flag set on link-detect change
// - loss-change cleared by clear read or unlock
// - check-fail flag on errors while link present, outside selftest mode
// - check-fail cleared by clear register read
// - remote lock shown in bit 6
// - selftest fail flag and error count
// - synth lock in bit 2, resets one
// - link present bit 0, resets one
// - gpio live levels in bits 3:0
// - 8-bit selftest error count, resets zero
// - 16-bit check count over two bytes
// - temperature over/under flags clear on read
// - pin1 voltage over/under flags clear on read
// - pin0 voltage over/under flags clear on read
// - pin0 peak field, clears to zero
// - pin0 trough field, clears to seven
// - pin1 peak field, clears to zero
// - pin1 trough field, clears to seven
// - write one clears check-fail indications
// - write one clears selftest counter
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`include "lssr_consts.vh"
module lssr_status_regs (
   input wire sys_clk_i, // 40 MHz system clock
   input wire reset_i, // synchronous reset, active high
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb write
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output wire pready, // apb ready
   output reg [31:0] prdata, // apb read data
   output reg pslverr, // apb error, unmapped address
   input wire backlink_present_i, // back channel link valid
   input wire check_fail_event_i, // back channel check error pulse
   input wire selftest_mode_i, // selftest mode active
   input wire fast_synth_locked_i, // forward synth lock
   input wire remote_locked_i, // remote receiver lock
   input wire [3:0] pin_input_levels_i, // gpio pin levels
   input wire temp_over_i, // temperature above upper limit
   input wire temp_under_i, // temperature below lower limit
   input wire [2:0] pin0_reading_i, // pin0 voltage reading
   input wire pin0_over_i, // pin0 above upper limit
   input wire pin0_under_i, // pin0 below lower limit
   input wire [2:0] pin1_reading_i, // pin1 voltage reading
   input wire pin1_over_i, // pin1 above upper limit
   input wire pin1_under_i, // pin1 below lower limit
   output wire backlink_present_o, // link present status
   output wire check_fail_flag_o // check failure status
);
   // ==========================================
   // bus decode
   wire [9:0] word_idx = paddr[11:2];
   wire access_w = psel && penable;
   wire rd_w = access_w && !pwrite;
   wire wr_w = access_w && pwrite;
   wire idx_gen = (word_idx == {2'h0, `LSSR_IDX_GEN_STATUS});
   wire idx_gpio = (word_idx == {2'h0, `LSSR_IDX_GPIO_LEVELS});
   wire idx_stc = (word_idx == {2'h0, `LSSR_IDX_SELFTEST_CNT});
   wire idx_clo = (word_idx == {2'h0, `LSSR_IDX_CHECK_CNT_LO});
   wire idx_chi = (word_idx == {2'h0, `LSSR_IDX_CHECK_CNT_HI});
   wire idx_al = (word_idx == {2'h0, `LSSR_IDX_ALARM_FLAGS});
   wire idx_p0 = (word_idx == {2'h0, `LSSR_IDX_PIN0_EXTREMES});
   wire idx_p1 = (word_idx == {2'h0, `LSSR_IDX_PIN1_EXTREMES});
   wire idx_ctl = (word_idx == {2'h0, `LSSR_IDX_BACKLINK_CTRL});
   wire mapped_w = idx_gen | idx_gpio | idx_stc | idx_clo | idx_chi | idx_al | idx_p0 | idx_p1 | idx_ctl;

   // single-cycle access phase: every register answers at once
   assign pready = 1'b1;

   // ==========================================
   // control register: self-clearing strobes, bits 4 and 2:0 kept
   reg [7:0] ctrl_q;
   wire ctl_wr = wr_w && idx_ctl && paddr[1:0] == 2'h0;
   wire check_clr_w = (ctl_wr && pwdata[`LSSR_CTRL_CHECK_CLR]) || (rd_w && idx_ctl);
   wire selftest_clr_w = ctl_wr && pwdata[`LSSR_CTRL_SELFTEST_CLR];

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         ctrl_q <= 8'h00;
      end else if (ctl_wr) begin
         // strobe bits never stored; reserved 7:6 read zero
         ctrl_q <= {2'h0, 1'b0, pwdata[4], 1'b0, pwdata[2:0]};
      end
   end

   // ==========================================
   // link status
   reg present_q;
   reg present_d1_q;
   reg synth_q;
   reg remote_q;
   reg loss_chg_q;
   reg check_fail_q;
   wire present_chg = present_q != present_d1_q;

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         present_q <= `LSSR_RST_PRESENT;
         present_d1_q <= `LSSR_RST_PRESENT;
         synth_q <= `LSSR_RST_SYNTH_LOCK;
         remote_q <= 1'b0;
         loss_chg_q <= 1'b0;
         check_fail_q <= 1'b0;
      end else begin
         present_q <= backlink_present_i;
         present_d1_q <= present_q;
         synth_q <= fast_synth_locked_i;
         remote_q <= remote_locked_i;
         // set wins over a clearing read and over loss of lock, which otherwise clears it
         if (present_chg) begin
            loss_chg_q <= 1'b1;
         end else if (check_clr_w || !synth_q) begin
            loss_chg_q <= 1'b0;
         end
         if (check_fail_event_i && present_q && !selftest_mode_i) begin
            check_fail_q <= 1'b1;
         end else if (check_clr_w) begin
            check_fail_q <= 1'b0;
         end
      end
   end

   assign backlink_present_o = present_q;
   assign check_fail_flag_o = check_fail_q;

   // ==========================================
   // error counters
   wire [7:0] selftest_count;
   wire [15:0] check_count;

   lssr_sat_counter #(.WIDTH(8)) u_selftest_cnt (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clear_i(selftest_clr_w),
      .event_i(check_fail_event_i && selftest_mode_i),
      .count_o(selftest_count)
   );

   lssr_sat_counter #(.WIDTH(16)) u_check_cnt (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clear_i(check_clr_w),
      .event_i(check_fail_event_i && present_q && !selftest_mode_i),
      .count_o(check_count)
   );

   wire selftest_fail = selftest_count != 8'h00;

   // ==========================================
   // alarm flags, clear on read, set wins
   reg [5:0] alarm_q;
   wire [5:0] alarm_set = {temp_over_i, temp_under_i, pin1_over_i, pin1_under_i, pin0_over_i, pin0_under_i};
   wire al_rd = rd_w && idx_al;

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         alarm_q <= 6'h00;
      end else if (al_rd) begin
         alarm_q <= alarm_set;
      end else begin
         alarm_q <= alarm_q | alarm_set;
      end
   end

   // ==========================================
   // voltage extremes
   wire [2:0] p0_peak;
   wire [2:0] p0_trough;
   wire [2:0] p1_peak;
   wire [2:0] p1_trough;

   lssr_extreme_catch u_pin0 (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .reading_i(pin0_reading_i),
      .over_i(pin0_over_i),
      .under_i(pin0_under_i),
      .read_clear_i(rd_w && idx_p0),
      .peak_o(p0_peak),
      .trough_o(p0_trough)
   );

   lssr_extreme_catch u_pin1 (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .reading_i(pin1_reading_i),
      .over_i(pin1_over_i),
      .under_i(pin1_under_i),
      .read_clear_i(rd_w && idx_p1),
      .peak_o(p1_peak),
      .trough_o(p1_trough)
   );

   // reserved r/w bits of the extreme registers, kept for software
   reg [1:0] p0_rsv_q;
   reg [1:0] p1_rsv_q;
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         p0_rsv_q <= 2'h0;
         p1_rsv_q <= 2'h0;
      end else begin
         if (wr_w && idx_p0) begin
            p0_rsv_q <= {pwdata[7], pwdata[3]};
         end
         if (wr_w && idx_p1) begin
            p1_rsv_q <= {pwdata[7], pwdata[3]};
         end
      end
   end

   // ==========================================
   // read mux
   reg [7:0] rd_byte;
   always @* begin
      rd_byte = 8'h00;
      if (idx_gen) begin
         rd_byte[`LSSR_GS_PRESENT] = present_q;
         rd_byte[`LSSR_GS_CHECK_FAIL] = check_fail_q;
         rd_byte[`LSSR_GS_SYNTH_LOCK] = synth_q;
         rd_byte[`LSSR_GS_SELFTEST_FAIL] = selftest_fail;
         rd_byte[`LSSR_GS_LOSS_CHANGE] = loss_chg_q;
         rd_byte[`LSSR_GS_REMOTE_LOCK] = remote_q;
      end else if (idx_gpio) begin
         rd_byte = {4'h0, pin_input_levels_i};
      end else if (idx_stc) begin
         rd_byte = selftest_count;
      end else if (idx_clo) begin
         rd_byte = check_count[7:0];
      end else if (idx_chi) begin
         rd_byte = check_count[15:8];
      end else if (idx_al) begin
         // an alarm caught on the setup edge must be shown before the access edge clears it
         rd_byte = {2'h0, alarm_q | alarm_set};
      end else if (idx_p0) begin
         rd_byte = {p0_rsv_q[1], p0_peak, p0_rsv_q[0], p0_trough};
      end else if (idx_p1) begin
         rd_byte = {p1_rsv_q[1], p1_peak, p1_rsv_q[0], p1_trough};
      end else if (idx_ctl) begin
         rd_byte = ctrl_q;
      end
   end

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         // registered next-cycle data would miss the sample edge, so load in setup
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
            pslverr <= !mapped_w;
         end
      end
   end
endmodule

// ### lssr_status_props.sv
// concurrent checks on the status register bank ports
`timescale 1ns/10ps
module lssr_status_props (
   input wire sys_clk_i, // clock
   input wire reset_i, // sync reset
   input wire psel, // apb select
   input wire penable, // apb access
   input wire pwrite, // apb write
   input wire [11:0] paddr, // apb address
   input wire pready, // apb ready
   input wire [31:0] prdata, // apb read data
   input wire pslverr, // apb error
   input wire backlink_present_i, // link level
   input wire check_fail_event_i, // error pulse
   input wire selftest_mode_i, // selftest mode
   input wire [3:0] pin_input_levels_i, // gpio levels
   input wire backlink_present_o, // link status
   input wire check_fail_flag_o // check flag
);
   // ==========================================
   // decode helpers
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   wire [9:0] idx = paddr[11:2];
   wire setup = psel && !penable;
   wire mapped = (idx == 10'h049) || (idx >= 10'h052 && idx <= 10'h059);
   wire clr_acc = psel && penable && (idx == 10'h049);
   a_ready_high: assert property (pready) else $error("ready low");
   a_link_follows: assert property (!$past(reset_i) |-> backlink_present_o == $past(backlink_present_i))
      else $error("link status lags wrong");
   a_gpio_live: assert property (setup && !pwrite && idx == 10'h053 |=> prdata[7:0] == {4'h0, $past(pin_input_levels_i)})
      else $error("gpio read wrong");
   a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
   a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   a_mapped_ok: assert property (setup && mapped |=> !pslverr) else $error("mapped refused");
   a_flag_sets: assert property (check_fail_event_i && backlink_present_i && $past(backlink_present_i)
      && !selftest_mode_i && !$past(selftest_mode_i) |-> ##[1:2] check_fail_flag_o) else $error("flag not set");
   a_flag_holds: assert property (check_fail_flag_o && !clr_acc |=> check_fail_flag_o)
      else $error("flag lost");
   a_flag_cause: assert property ($rose(check_fail_flag_o) |-> $past(check_fail_event_i)
      || $past(check_fail_event_i, 2)) else $error("flag without error");
endmodule
bind lssr_status_regs lssr_status_props u_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .backlink_present_i(backlink_present_i), .check_fail_event_i(check_fail_event_i),
   .selftest_mode_i(selftest_mode_i), .pin_input_levels_i(pin_input_levels_i),
   .backlink_present_o(backlink_present_o), .check_fail_flag_o(check_fail_flag_o));

// ### lssr_remote_model.sv
// remote receiver model driving link, error and lock lines
`timescale 1ns/10ps
module lssr_remote_model (
   input wire clk_i, // system clock
   output reg link_o = 1'b1, // link valid level
   output reg event_o = 1'b0, // one check error per pulse
   output reg lock_o = 1'b0 // remote receiver lock
);
   // ==========================================
   // spaced pulses so each error is a distinct event
   task errors(input integer n);
      integer i;
      for (i = 0; i < n; i = i + 1) begin
         @(posedge clk_i);
         event_o <= 1'b1;
         @(posedge clk_i);
         event_o <= 1'b0;
      end
      repeat (2) @(posedge clk_i);
   endtask
   task drive(input l, input k);
      @(posedge clk_i);
      link_o <= l;
      lock_o <= k;
      repeat (3) @(posedge clk_i);
   endtask
endmodule

// ### tb_lssr_status_regs.sv
// self-checking bench for the status register bank
`timescale 1ns/10ps
module tb_lssr_status_regs;
   reg sys_clk_i = 1'b0;
   reg reset_i = 1'b1;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, selftest = 1'b0, synth = 1'b1, err;
   reg [11:0] paddr = 12'h0;
   reg [31:0] pwdata = 32'h0, rd;
   reg [3:0] pins = 4'h0;
   reg [5:0] alm = 6'h0;
   reg [5:0] rdg = 6'h0;
   wire pready, pslverr, link, ev, lock;
   wire [31:0] prdata;
   integer num_errors = 0, comparisons = 0, cycles = 0, i;
   always #12.5 sys_clk_i = ~sys_clk_i;
   lssr_remote_model far (.clk_i(sys_clk_i), .link_o(link), .event_o(ev), .lock_o(lock));
   lssr_status_regs dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .backlink_present_i(link), .check_fail_event_i(ev), .selftest_mode_i(selftest),
      .fast_synth_locked_i(synth), .remote_locked_i(lock), .pin_input_levels_i(pins),
      .temp_over_i(alm[5]), .temp_under_i(alm[4]), .pin1_over_i(alm[3]), .pin1_under_i(alm[2]),
      .pin0_over_i(alm[1]), .pin0_under_i(alm[0]), .pin0_reading_i(rdg[2:0]), .pin1_reading_i(rdg[5:3]),
      .backlink_present_o(), .check_fail_flag_o());
   // ==========================================
   // bus tasks and verdict
   task summarize;
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         num_errors = num_errors + 1;
         summarize;
      end
   end
   task apb(input w, input [7:0] idx, input [31:0] wd);
      @(posedge sys_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      @(posedge sys_clk_i);
      while (pready !== 1'b1) @(posedge sys_clk_i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk(input [7:0] idx, input [7:0] exp, input e = 1'b0);
      apb(1'b0, idx, 32'h0);
      comparisons = comparisons + 1;
      if (rd !== {24'h0, exp} || err !== e) begin
         num_errors = num_errors + 1;
         $display("[ERR] reg %h expected %h/%b seen %h/%b", idx, exp, e, rd, err);
      end
   endtask
   task alarm(input [5:0] a, input [5:0] r, input [7:0] e57, input [7:0] e58, input [7:0] e59);
      @(posedge sys_clk_i);
      alm <= a;
      rdg <= r;
      repeat (2) @(posedge sys_clk_i);
      alm <= 6'h0;
      chk(8'h57, e57);
      chk(8'h57, 8'h00);
      chk(8'h58, e58);
      chk(8'h58, 8'h07);
      chk(8'h59, e59);
      chk(8'h59, 8'h07);
   endtask
   initial begin
      repeat (12) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      chk(8'h52, 8'h05);
      chk(8'h54, 8'h00);
      chk(8'h55, 8'h00);
      chk(8'h56, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge sys_clk_i);
         pins <= i * 5;
         chk(8'h53, i * 5);
      end
      apb(1'b1, 8'h52, 32'hff);
      chk(8'h52, 8'h05);
      chk(8'h5a, 8'h00, 1'b1);
      far.errors(3);
      chk(8'h55, 8'h03);
      chk(8'h56, 8'h00);
      chk(8'h52, 8'h07);
      apb(1'b1, 8'h49, 32'h8);
      chk(8'h52, 8'h05);
      chk(8'h55, 8'h00);
      far.errors(1);
      apb(1'b0, 8'h49, 32'h0);
      chk(8'h52, 8'h05);
      selftest <= 1'b1;
      far.errors(260);
      chk(8'h54, 8'hff);
      chk(8'h52, 8'h0d);
      chk(8'h55, 8'h00);
      apb(1'b1, 8'h49, 32'h37);
      chk(8'h54, 8'h00);
      chk(8'h49, 8'h17);
      selftest <= 1'b0;
      far.drive(1'b0, 1'b1);
      far.errors(1);
      chk(8'h52, 8'h54);
      apb(1'b0, 8'h49, 32'h0);
      chk(8'h52, 8'h44);
      far.drive(1'b1, 1'b1);
      chk(8'h52, 8'h55);
      synth <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk(8'h52, 8'h41);
      synth <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk(8'h52, 8'h45);
      alarm(6'h26, {3'd2, 3'd5}, 8'h26, 8'h57, 8'h02);
      alarm(6'h19, {3'd6, 3'd1}, 8'h19, 8'h01, 8'h67);
      alm <= 6'h20;
      chk(8'h57, 8'h20);
      chk(8'h57, 8'h20);
      alm <= 6'h0;
      chk(8'h57, 8'h20);
      chk(8'h57, 8'h00);
      summarize;
   end
endmodule
